// *** hdl/pfl_framer.sv ***
// frame length handling, header generation and air timing of the framer
// assumes octet streams synchronous to clk_sys_i, one octet per valid cycle
`default_nettype none
`include "pfl_defines.svh"
// Summary of operation
// - payload length stays within 0 to 127 octets in both directions.
// - payload length comes from the PHY header length field.
// - last two payload octets are the check sequence, the rest MAC data.
// - received frames of length zero are dropped, never reported to host.
// - length 0-4 reserved, 5 ack, 6-8 reserved, 9 and up general frame.
// - sync and PHY headers take 160 us and 32 us at 250 kb/s.
// - maximum payload air time 4.064, 2.032, 1.016, 0.508 ms by rate.
// - MAC header is control field, sequence number, then optional addressing.
// - addressing 0 to 20 octets, security header 0/5/6/10/14 octets.
// - low seven header bits are length, top bit passed through untouched.
// - transmit sends four zero preamble octets then delimiter 0xA7.
module pfl_framer (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  // configuration
  input  wire logic [1:0]       rate_i,
  // transmit: header octet from host, preamble and delimiter out
  input  wire logic             tx_start_i,
  input  wire logic [7:0]       tx_phr_i,
  output logic                  tx_valid_o,
  output logic [7:0]            tx_data_o,
  output logic                  tx_busy_o,
  output logic [23:0]           tx_air_cyc_o,
  // receive: octets from demodulator after delimiter
  input  wire logic             rx_valid_i,
  input  wire logic [7:0]       rx_data_i,
  input  wire logic             rx_sof_i,
  output logic                  rx_valid_o,
  output logic [7:0]            rx_data_o,
  output logic                  rx_fcs_o,
  output logic                  rx_start_o,
  output logic                  rx_end_o,
  output logic [1:0]            rx_cls_o,
  output logic                  rx_res_bit_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [1:0] cls_of(input logic [6:0] len);
    if (len == `PFL_LEN_ACK) begin
      cls_of = pfl_pkg::PFL_CLS_ACK;
    end else if (len <= `PFL_LEN_RSV_HI
                 || (len >= `PFL_LEN_RSV2_LO && len <= `PFL_LEN_RSV2_HI)) begin
      cls_of = pfl_pkg::PFL_CLS_RSV;
    end else begin
      cls_of = pfl_pkg::PFL_CLS_MPDU;
    end
  endfunction

  function automatic logic [23:0] oct_cyc(input logic [1:0] r);
    case (r)
      pfl_pkg::PFL_RATE_250:  oct_cyc = 24'(`PFL_OCT_250_CYC);
      pfl_pkg::PFL_RATE_500:  oct_cyc = 24'(`PFL_OCT_500_CYC);
      pfl_pkg::PFL_RATE_1000: oct_cyc = 24'(`PFL_OCT_1000_CYC);
      default:                oct_cyc = 24'(`PFL_OCT_2000_CYC);
    endcase
  endfunction

  // ----------------------------------------
  // transmit sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    PFL_TX_IDLE = 3'h1,
    PFL_TX_PRE  = 3'h2,
    PFL_TX_SFD  = 3'h4
  } pfl_tx_st_t;
  pfl_tx_st_t tx_st_q;
  logic [2:0] pre_cnt_q;

  // header octets only; the payload follows from the host stream downstream
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_st_q    <= PFL_TX_IDLE;
      pre_cnt_q  <= 3'h0;
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
      tx_busy_o  <= 1'b0;
    end else begin
      tx_valid_o <= 1'b0;
      case (tx_st_q)
        PFL_TX_IDLE: begin
          tx_busy_o <= 1'b0;
          if (tx_start_i) begin
            pre_cnt_q <= 3'h0;
            tx_busy_o <= 1'b1;
            tx_st_q   <= PFL_TX_PRE;
          end
        end
        PFL_TX_PRE: begin
          tx_valid_o <= 1'b1;
          tx_data_o  <= `PFL_PRE_VAL;
          pre_cnt_q  <= pre_cnt_q + 3'h1;
          if (pre_cnt_q == `PFL_PRE_OCTETS - 3'h1) begin
            tx_st_q <= PFL_TX_SFD;
          end
        end
        PFL_TX_SFD: begin
          tx_valid_o <= 1'b1;
          tx_data_o  <= `PFL_SFD_VAL;
          tx_st_q    <= PFL_TX_IDLE;
        end
        default: tx_st_q <= PFL_TX_IDLE;
      endcase
    end
  end

  // header time plus octet time at rate; top header bit excluded
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_air_cyc_o <= 24'h000000;
    end else if (tx_start_i && tx_st_q == PFL_TX_IDLE) begin
      tx_air_cyc_o <= 24'(`PFL_SHR_CYC) + 24'(`PFL_PHR_CYC)
                    + 24'(tx_phr_i[6:0]) * oct_cyc(rate_i);
    end
  end

  // ----------------------------------------
  // receive length tracking
  // ----------------------------------------
  logic       rx_act_q;
  logic [6:0] rx_left_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_act_q     <= 1'b0;
      rx_left_q    <= 7'h00;
      rx_valid_o   <= 1'b0;
      rx_data_o    <= 8'h00;
      rx_fcs_o     <= 1'b0;
      rx_start_o   <= 1'b0;
      rx_end_o     <= 1'b0;
      rx_cls_o     <= 2'h0;
      rx_res_bit_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      rx_start_o <= 1'b0;
      rx_end_o   <= 1'b0;
      rx_fcs_o   <= 1'b0;
      if (rx_sof_i && rx_valid_i) begin
        // zero length: header invalid, nothing reaches the host
        if ((rx_data_i & `PFL_LEN_MSK) != 8'h00) begin
          rx_act_q     <= 1'b1;
          rx_left_q    <= rx_data_i[6:0];
          rx_valid_o   <= 1'b1;
          rx_data_o    <= rx_data_i;
          rx_start_o   <= 1'b1;
          rx_cls_o     <= cls_of(rx_data_i[6:0]);
          rx_res_bit_o <= rx_data_i[`PFL_RES_BIT];
        end else begin
          rx_act_q <= 1'b0;
        end
      end else if (rx_act_q && rx_valid_i) begin
        rx_valid_o <= 1'b1;
        rx_data_o  <= rx_data_i;
        rx_fcs_o   <= (rx_left_q <= `PFL_FCS_OCTETS);
        rx_left_q  <= rx_left_q - 7'h01;
        if (rx_left_q == 7'h01) begin
          rx_act_q <= 1'b0;
          rx_end_o <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_zero_len_drop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rx_sof_i && rx_valid_i && rx_data_i[6:0] == 7'h00) |=> !rx_start_o && !rx_valid_o)
    else $error("zero length frame reported");
  a_ack_class: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rx_sof_i && rx_valid_i && rx_data_i[6:0] == 7'h05) |=> rx_cls_o == 2'h1)
    else $error("length five not classed ack");
  a_rsv_class: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rx_sof_i && rx_valid_i && rx_data_i[6:0] inside {[7'h01:7'h04], [7'h06:7'h08]})
    |=> rx_cls_o == 2'h0)
    else $error("reserved length misclassed");
  a_phr_pass: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rx_start_o |-> rx_data_o == $past(rx_data_i) && rx_res_bit_o == rx_data_o[7])
    else $error("header octet altered");
  a_pre_seq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tx_start_i && tx_st_q == PFL_TX_IDLE) |=> ##1 (tx_valid_o && tx_data_o == 8'h00) [*4]
    ##1 (tx_valid_o && tx_data_o == 8'hA7))
    else $error("sync header sequence wrong");
  a_air_time: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tx_start_i && tx_st_q == PFL_TX_IDLE && tx_phr_i[6:0] == 7'h7F && rate_i == 2'h0)
    |=> tx_air_cyc_o == 24'h067E80)
    else $error("air time at 250 wrong");
  a_hdr_time: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tx_start_i && tx_st_q == PFL_TX_IDLE && tx_phr_i[6:0] == 7'h00)
    |=> tx_air_cyc_o == 24'h004B00)
    else $error("header time wrong");
  a_fcs_mark: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rx_end_o |-> rx_fcs_o && $past(rx_fcs_o)
      || $past(rx_start_o) && $past(rx_data_o[6:0]) == 7'h01)
    else $error("check sequence not marked");
  // an open frame always has octets left, so nothing past the length is forwarded
  a_len_bound: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rx_act_q |-> rx_left_q != 7'h00)
    else $error("frame open with no octets left");
  a_rx_follow: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rx_act_q && rx_valid_i && !rx_sof_i) |=> rx_valid_o && rx_data_o == $past(rx_data_i))
    else $error("payload octet not forwarded");
  a_mpdu_class: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rx_sof_i && rx_valid_i && rx_data_i[6:0] >= 7'h09) |=> rx_cls_o == 2'h2)
    else $error("general frame misclassed");
  a_busy_span: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tx_start_i && tx_st_q == PFL_TX_IDLE) |=> tx_busy_o [*6] ##1 !tx_busy_o)
    else $error("busy span wrong");
  c_tx_frame: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    tx_valid_o && tx_data_o == 8'hA7);
  c_rx_ack: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    rx_start_o && rx_cls_o == 2'h1);
  c_rx_end: cover property (@(posedge clk_sys_i) disable iff (rst_i) rx_end_o);
  c_tx_refused: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    tx_start_i && tx_st_q != PFL_TX_IDLE);
  c_rx_drop: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    rx_sof_i && rx_valid_i && rx_data_i[6:0] == 7'h00);
endmodule
`default_nettype wire

// *** hdl/pfl_defines.svh ***
// constants of the frame length and timing block
// assumes inclusion by bare name from hdl/ files only
`ifndef PFL_DEFINES_SVH
`define PFL_DEFINES_SVH
`define PFL_CLK_MHZ       100
`define PFL_MAX_LEN       7'h7F
`define PFL_LEN_ACK       7'h05
`define PFL_LEN_RSV_HI    7'h04
`define PFL_LEN_RSV2_LO   7'h06
`define PFL_LEN_RSV2_HI   7'h08
`define PFL_FCS_OCTETS    7'h02
`define PFL_MHR_MIN       7'h03
`define PFL_PRE_OCTETS    3'h4
`define PFL_PRE_VAL       8'h00
`define PFL_SFD_VAL       8'hA7
`define PFL_SHR_US        160
`define PFL_PHR_US        32
`define PFL_HDR_KBPS      250
// cycles per payload octet at each rate: 8 bits * 1000 / kbps * MHz
`define PFL_SHR_CYC       (`PFL_SHR_US * `PFL_CLK_MHZ)
`define PFL_PHR_CYC       (`PFL_PHR_US * `PFL_CLK_MHZ)
`define PFL_OCT_250_CYC   (8000 / 250 * `PFL_CLK_MHZ)
`define PFL_OCT_500_CYC   (8000 / 500 * `PFL_CLK_MHZ)
`define PFL_OCT_1000_CYC  (8000 / 1000 * `PFL_CLK_MHZ)
`define PFL_OCT_2000_CYC  (8000 / 2000 * `PFL_CLK_MHZ)
`define PFL_MAXPSDU_250_US  4064
`define PFL_MAXPSDU_500_US  2032
`define PFL_MAXPSDU_1000_US 1016
`define PFL_MAXPSDU_2000_US 508
`define PFL_LEN_MSK       8'h7F
`define PFL_RES_BIT       7
`endif

// *** hdl/pfl_pkg.sv ***
// types of the frame length and timing block
// assumes pfl_defines.svh compiled alongside
`default_nettype none
package pfl_pkg;
  typedef enum logic [1:0] {
    PFL_RATE_250  = 2'h0,
    PFL_RATE_500  = 2'h1,
    PFL_RATE_1000 = 2'h2,
    PFL_RATE_2000 = 2'h3
  } pfl_rate_t;
  typedef enum logic [1:0] {
    PFL_CLS_RSV  = 2'h0,
    PFL_CLS_ACK  = 2'h1,
    PFL_CLS_MPDU = 2'h2
  } pfl_cls_t;
endpackage
`default_nettype wire

// *** tb/pfl_air_model.sv ***
// remote radio model: sends one received frame as an octet stream
// assumes a go pulse only while busy_o is low
`default_nettype none
module pfl_air_model (
  // clock
  input  wire logic       clk_sys_i,
  // request
  input  wire logic       go_i,
  input  wire logic [7:0] phr_i,
  // octet stream
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_sof_o,
  output logic            busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_q = 8'h00;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    rx_sof_o   = 1'b0;
    busy_o     = 1'b0;
  end
  always @(posedge clk_sys_i) begin
    rx_sof_o <= 1'b0;
    if (go_i && !busy_o) begin
      rx_valid_o <= 1'b1;
      rx_sof_o   <= 1'b1;
      rx_data_o  <= phr_i;
      left_q     <= {1'b0, phr_i[6:0]};
      busy_o     <= 1'b1;
    end else if (left_q != 8'h00) begin
      rx_data_o <= left_q ^ 8'h5A;
      left_q    <= left_q - 8'h01;
    end else begin
      // released line toggles so a stale octet is never mistaken
      rx_valid_o <= 1'b0;
      busy_o     <= 1'b0;
      rx_data_o  <= ~rx_data_o;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_pfl_framer.sv ***
// bench of the framer: header table first, then hand tests
// assumes the air model drives the receive stream
`default_nettype none
module tb_pfl_framer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_i = 1'b0, rst_i = 1'b1, tx_start_i = 1'b0, go = 1'b0;
  logic [1:0]  rate_i = 2'h0, cls;
  logic [7:0]  tx_phr_i = 8'h00, phr = 8'h00, rxd, txd, rxo;
  logic        txv, busy, rxv, sof, rv, fcs, st, en, res, mbusy, clr = 1'b0;
  logic [23:0] air, txi, nv, nf, ns, ne, len = 24'h0;
  int          error_cnt = 0, samples_checked = 0;
  // {expected class, rate, header}
  logic [11:0] rows [8] = '{12'h000, 12'h184, 12'h605, 12'h308, 12'hA09, 12'hBFF, 12'h101,
                            12'h87F};
  always #5 clk_sys_i = ~clk_sys_i;
  pfl_framer u_pfl_framer (.clk_sys_i, .rst_i, .rate_i, .tx_start_i, .tx_phr_i,
    .tx_valid_o(txv), .tx_data_o(txd), .tx_busy_o(busy), .tx_air_cyc_o(air),
    .rx_valid_i(rxv), .rx_data_i(rxd), .rx_sof_i(sof), .rx_valid_o(rv),
    .rx_data_o(rxo), .rx_fcs_o(fcs), .rx_start_o(st), .rx_end_o(en),
    .rx_cls_o(cls), .rx_res_bit_o(res));
  pfl_air_model u_pfl_air_model (.clk_sys_i, .go_i(go), .phr_i(phr),
    .rx_valid_o(rxv), .rx_data_o(rxd), .rx_sof_o(sof), .busy_o(mbusy));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait for both ends to go idle
  task automatic wait_idle(input int n);
    int i;
    for (i = 0; i < n && (busy !== 1'b0 || mbusy !== 1'b0); i++) @(posedge clk_sys_i);
    if (i == n) begin
      error_cnt++;
      close_out();
    end
  endtask
  function automatic logic [23:0] air_exp(input logic [7:0] p, input logic [1:0] r);
    return 24'h4B00 + p[6:0] * (24'hC80 >> r);
  endfunction
  // counters have this one driver; the sequence clears them through clr
  always @(posedge clk_sys_i) begin
    if (clr) begin
      {txi, nv, nf, ns, ne} <= '0;
    end else begin
      if (txv === 1'b1) begin
        chk({16'h0, txd}, txi < 24'h4 ? 24'h00 : 24'hA7);
        chk({23'h0, busy}, 24'h1);
        txi <= txi + 24'h1;
      end
      if (st === 1'b1) chk({16'h0, rxo}, {16'h0, phr});
      // model payload counts down from the length, xored with 5A
      if (rv === 1'b1 && st !== 1'b1) begin
        chk({16'h0, rxo}, ((len + 24'h1 - nv) & 24'h0000FF) ^ 24'h00005A);
      end
      nv <= nv + (rv === 1'b1);
      nf <= nf + (fcs === 1'b1);
      ns <= ns + (st === 1'b1);
      ne <= ne + (en === 1'b1);
    end
  end
  // ----------------
  // main sequence
  // ----------------
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys_i);
      clr <= 1'b1;
      len = {17'h0, rows[k][6:0]};
      tx_start_i <= 1'b1;
      tx_phr_i <= rows[k][7:0];
      rate_i <= rows[k][9:8];
      go <= 1'b1;
      phr <= rows[k][7:0];
      @(posedge clk_sys_i);
      tx_start_i <= 1'b0;
      go <= 1'b0;
      clr <= 1'b0;
      #1 chk(air, air_exp(rows[k][7:0], rows[k][9:8]));
      wait_idle(200);
      repeat (3) @(posedge clk_sys_i);
      chk(txi, 24'h5);
      chk(nv, len == 24'h0 ? 24'h0 : len + 24'h1);
      chk(nf, len > 24'h2 ? 24'h2 : len);
      chk({ns[11:0], ne[11:0]}, len == 24'h0 ? 24'h0 : 24'h001001);
      if (len != 24'h0) begin
        chk({21'h0, cls, res}, {21'h0, rows[k][11:10], rows[k][7]});
      end
    end
    // second start while busy must not disturb the frame
    @(posedge clk_sys_i);
    clr <= 1'b1;
    tx_start_i <= 1'b1;
    tx_phr_i <= 8'h05;
    rate_i <= 2'h0;
    @(posedge clk_sys_i);
    tx_start_i <= 1'b0;
    clr <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    tx_start_i <= 1'b1;
    tx_phr_i <= 8'hFF;
    @(posedge clk_sys_i);
    tx_start_i <= 1'b0;
    #1 wait_idle(20);
    #1 chk(air, air_exp(8'h05, 2'h0));
    chk(txi, 24'h5);
    // reset in mid-frame clears the transmit side
    @(posedge clk_sys_i);
    tx_start_i <= 1'b1;
    @(posedge clk_sys_i);
    tx_start_i <= 1'b0;
    rst_i <= 1'b1;
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1 chk(air, 24'h0);
    chk({18'h0, busy, txv, rv, st, en, fcs}, 24'h0);
    chk({21'h0, cls, res}, 24'h0);
    close_out();
  end
endmodule
`default_nettype wire
